//--- hdl/i2cce_defs.vh
`ifndef I2CCE_DEFS_VH
`define I2CCE_DEFS_VH

// counter and byte geometry
`define I2CCE_CNT_W      12
`define I2CCE_BYTE_W     8
`define I2CCE_MSB        7
`define I2CCE_RW_BIT     0
`define I2CCE_IDX_W      4
`define I2CCE_IDX_FIRST  4'd0
`define I2CCE_IDX_LAST   4'd7
`define I2CCE_IDX_ACK    4'd8
`define I2CCE_IDX_STEP   4'd1
`define I2CCE_CNT_STEP   1'b1

// reset values
`define I2CCE_RST_LOW    1'b0
`define I2CCE_RST_HIGH   1'b1
`define I2CCE_RST_BYTE   8'h00

// open-drain pin levels and enables
`define I2CCE_LINE_LOW   1'b0
`define I2CCE_OE_DRIVE   1'b0
`define I2CCE_OE_FLOAT   1'b1

`endif

//--- hdl/i2cce_sync.v
`timescale 1ns/10ps
`default_nettype none

module i2cce_sync #(
  parameter WIDTH   = 2,
  parameter RST_VAL = 2'b11
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] d_i,
  output reg  [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta;

  // two stages; the first is seen only by the second
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // i2cce_sync

`default_nettype wire

//--- hdl/i2cce_engine.v
// Function
// RULE1 - sample clock after rise-time interval elapses
// RULE2 - pause high counter while clock held low
// RULE3 - software programs rise limit with loop delay
// RULE4 - idle bus plus start request issues start
// RULE5 - repeated start only after current byte
// RULE6 - start done sets flag, event interrupt
// RULE7 - status one read, address write clears
// RULE8 - ten-bit header sent flag, cleared likewise
// RULE9 - address done flag, cleared reading both statuses
// RULE10 - address lsb selects send or receive
// RULE11 - ten-bit read: header, address, restart, header
// RULE12 - direction flag shows send or receive
// RULE13 - hold clock low while events outstanding
// RULE14 - transmit waits for first data byte
// RULE15 - ack sets transmit empty, buffered interrupt
// RULE16 - empty holding at byte end: finished, hold
// RULE17 - software refills early or paces on finished
// RULE18 - stop request ends transfer, drops controller role
// RULE19 - stop clears transmit empty and finished
// RULE20 - receive: ack if enabled, then receive full (code sets receive full at the end of bit 8, before the ack bit)
// RULE21 - unread byte at next end: finished, hold
// RULE22 - bytes msb first, ack in ninth clock
// RULE23 - input clock at least four or eight MHz
// RULE24 - arbitration loss drops role, releases clock
`timescale 1ns/10ps
`default_nettype none
`include "i2cce_defs.vh"

module i2cce_engine #(
  parameter CNT_W = `I2CCE_CNT_W
) (
  input  wire                     sys_clk_i,
  input  wire                     rst_n_i,
  input  wire                     scl_i,
  input  wire                     sda_i,
  output reg                      scl_o,
  output reg                      scl_oe_n_o,
  output reg                      sda_o,
  output reg                      sda_oe_n_o,
  input  wire [CNT_W-1:0]         clock_period_setting_i,
  input  wire [CNT_W-1:0]         rise_limit_setting_i,
  input  wire                     start_req_i,
  input  wire                     stop_req_i,
  input  wire                     ack_enable_i,
  input  wire                     ten_bit_mode_i,
  input  wire                     event_irq_enable_i,
  input  wire                     buffer_irq_enable_i,
  input  wire                     data_wr_i,
  input  wire [`I2CCE_BYTE_W-1:0] data_wdata_i,
  input  wire                     data_rd_i,
  input  wire                     status_one_rd_i,
  input  wire                     status_two_rd_i,
  output reg  [`I2CCE_BYTE_W-1:0] data_rdata_o,
  output reg                      controller_role_flag_o,
  output reg                      start_done_flag_o,
  output reg                      header_sent_flag_o,
  output reg                      addr_done_flag_o,
  output reg                      direction_is_send_o,
  output reg                      transmit_empty_flag_o,
  output reg                      receive_full_flag_o,
  output reg                      byte_finished_flag_o,
  output reg                      bus_busy_o,
  output reg                      irq_o
);

  localparam [8:0] ST_IDLE  = 9'b000000001;
  localparam [8:0] ST_START = 9'b000000010;
  localparam [8:0] ST_SHOLD = 9'b000000100;
  localparam [8:0] ST_WAIT  = 9'b000001000;
  localparam [8:0] ST_LO    = 9'b000010000;
  localparam [8:0] ST_HI    = 9'b000100000;
  localparam [8:0] ST_RLOW  = 9'b001000000;
  localparam [8:0] ST_PLOW  = 9'b010000000;
  localparam [8:0] ST_PHI   = 9'b100000000;

  wire                     scl_s;
  wire                     sda_s;
  reg  [8:0]               state;
  reg  [CNT_W-1:0]         cnt;
  reg  [`I2CCE_IDX_W-1:0]  bit_idx;
  reg  [`I2CCE_BYTE_W-1:0] shifter;
  reg                      sda_q;
  reg                      sr1_seen;
  reg                      start_pend;
  reg                      stop_pend;
  reg                      addr_phase;
  reg                      hdr_phase;
  reg                      ten_done;
  reg                      rx_hold;
  reg                      nack_hold;

  // bus lines idle high, so the synchroniser resets high
  i2cce_sync #(
    .WIDTH   (2),
    .RST_VAL (2'b11)
  ) u_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({scl_i, sda_i}),
    .q_o     ({scl_s, sda_s})
  );

  // phase timing and per-bit data selection
  wire xfer_rx    = ~direction_is_send_o & ~addr_phase;
  // RULE1 - rise window check
  wire hi_stall   = (cnt >= rise_limit_setting_i) & ~scl_s;
  wire phase_done = (cnt >= clock_period_setting_i);
  wire next_cnt_hi_en = ~hi_stall;
  // RULE20 - ack only when enabled
  wire next_bit_rel = (bit_idx == `I2CCE_IDX_ACK) ?
                      (xfer_rx ? ~ack_enable_i : `I2CCE_OE_FLOAT) :
                      (xfer_rx ? `I2CCE_OE_FLOAT : shifter[`I2CCE_MSB]);
  // RULE7 - status one then address write
  wire addr_go = data_wr_i & sr1_seen & (start_done_flag_o | header_sent_flag_o);
  wire ack_seen = ~sda_s;

  // whole engine in one process; software clears first so hardware sets win
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state                  <= ST_IDLE;
      cnt                    <= {CNT_W{`I2CCE_RST_LOW}};
      bit_idx                <= `I2CCE_IDX_FIRST;
      shifter                <= `I2CCE_RST_BYTE;
      sda_q                  <= `I2CCE_RST_HIGH;
      sr1_seen               <= `I2CCE_RST_LOW;
      start_pend             <= `I2CCE_RST_LOW;
      stop_pend              <= `I2CCE_RST_LOW;
      addr_phase             <= `I2CCE_RST_LOW;
      hdr_phase              <= `I2CCE_RST_LOW;
      ten_done               <= `I2CCE_RST_LOW;
      rx_hold                <= `I2CCE_RST_LOW;
      nack_hold              <= `I2CCE_RST_LOW;
      scl_o                  <= `I2CCE_RST_LOW;
      sda_o                  <= `I2CCE_RST_LOW;
      scl_oe_n_o             <= `I2CCE_RST_HIGH;
      sda_oe_n_o             <= `I2CCE_RST_HIGH;
      data_rdata_o           <= `I2CCE_RST_BYTE;
      controller_role_flag_o <= `I2CCE_RST_LOW;
      start_done_flag_o      <= `I2CCE_RST_LOW;
      header_sent_flag_o     <= `I2CCE_RST_LOW;
      addr_done_flag_o       <= `I2CCE_RST_LOW;
      direction_is_send_o    <= `I2CCE_RST_LOW;
      transmit_empty_flag_o  <= `I2CCE_RST_LOW;
      receive_full_flag_o    <= `I2CCE_RST_LOW;
      byte_finished_flag_o   <= `I2CCE_RST_LOW;
      bus_busy_o             <= `I2CCE_RST_LOW;
      irq_o                  <= `I2CCE_RST_LOW;
    end else begin
      // open drain: only ever drive low
      scl_o <= `I2CCE_LINE_LOW;
      sda_o <= `I2CCE_LINE_LOW;
      sda_q <= sda_s;
      // busy tracks start and stop seen on the wire
      if (scl_s && sda_q && !sda_s) begin
        bus_busy_o <= 1'b1;
      end else if (scl_s && !sda_q && sda_s) begin
        bus_busy_o <= 1'b0;
      end
      // RULE6 - event and buffer interrupt
      irq_o <= (event_irq_enable_i & (start_done_flag_o | header_sent_flag_o |
               addr_done_flag_o | byte_finished_flag_o)) |
               (event_irq_enable_i & buffer_irq_enable_i &
               (transmit_empty_flag_o | receive_full_flag_o));
      // clear sequences start with a status one read
      if (status_one_rd_i) begin
        sr1_seen <= 1'b1;
      end else if (data_wr_i || data_rd_i || status_two_rd_i) begin
        sr1_seen <= 1'b0;
      end
      if (start_req_i) begin
        start_pend <= 1'b1;
      end
      if (stop_req_i && controller_role_flag_o) begin
        stop_pend <= 1'b1;
      end
      // holding register write; address bytes pass through it too
      if (data_wr_i) begin
        data_rdata_o <= data_wdata_i;
        if (direction_is_send_o && controller_role_flag_o && !start_done_flag_o &&
            !header_sent_flag_o) begin
          transmit_empty_flag_o <= 1'b0;
        end
        // RULE16 - finished cleared by write
        if (sr1_seen && direction_is_send_o) begin
          byte_finished_flag_o <= 1'b0;
        end
      end
      if (data_rd_i) begin
        receive_full_flag_o <= 1'b0;
        // RULE21 - finished cleared by read
        if (sr1_seen && !direction_is_send_o) begin
          byte_finished_flag_o <= 1'b0;
        end
      end
      // RULE8 - header flag cleared by write
      if (addr_go) begin
        start_done_flag_o  <= 1'b0;
        header_sent_flag_o <= 1'b0;
      end
      // RULE9 - cleared by both status reads
      if (status_two_rd_i && sr1_seen) begin
        addr_done_flag_o <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          scl_oe_n_o <= `I2CCE_OE_FLOAT;
          sda_oe_n_o <= `I2CCE_OE_FLOAT;
          cnt        <= {CNT_W{1'b0}};
          // RULE4 - start on idle bus
          if (start_pend && !bus_busy_o) begin
            start_pend             <= 1'b0;
            controller_role_flag_o <= 1'b1;
            state                  <= ST_START;
          end
        end
        ST_START: begin
          scl_oe_n_o <= `I2CCE_OE_FLOAT;
          sda_oe_n_o <= `I2CCE_OE_FLOAT;
          // RULE2 - pause while stretched
          if (next_cnt_hi_en) begin
            cnt <= cnt + `I2CCE_CNT_STEP;
          end
          if (phase_done) begin
            sda_oe_n_o <= `I2CCE_OE_DRIVE;
            cnt        <= {CNT_W{1'b0}};
            state      <= ST_SHOLD;
          end
        end
        ST_SHOLD: begin
          cnt <= cnt + `I2CCE_CNT_STEP;
          // RULE6 - start done flag
          if (phase_done) begin
            scl_oe_n_o        <= `I2CCE_OE_DRIVE;
            cnt               <= {CNT_W{1'b0}};
            start_done_flag_o <= 1'b1;
            bit_idx           <= `I2CCE_IDX_FIRST;
            state             <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // RULE13 - clock held low here
          scl_oe_n_o <= `I2CCE_OE_DRIVE;
          cnt        <= {CNT_W{1'b0}};
          if (addr_go) begin
            shifter    <= data_wdata_i;
            transmit_empty_flag_o <= 1'b0;
            addr_phase <= 1'b1;
            bit_idx    <= `I2CCE_IDX_FIRST;
            state      <= ST_LO;
            if (header_sent_flag_o) begin
              hdr_phase           <= 1'b0;
              ten_done            <= 1'b1;
              direction_is_send_o <= 1'b1;
            end else if (ten_bit_mode_i && !ten_done) begin
              hdr_phase           <= 1'b1;
              direction_is_send_o <= 1'b1;
            end else begin
              // RULE10 - lsb picks direction
              // RULE11 - read header after restart
              // RULE12 - direction flag updated
              hdr_phase           <= 1'b0;
              direction_is_send_o <= ~data_wdata_i[`I2CCE_RW_BIT];
            end
          end else if (start_done_flag_o || header_sent_flag_o || addr_done_flag_o) begin
            state <= ST_WAIT;
          end else if (rx_hold) begin
            // byte waits in the shifter until the holding register is free
            if (!byte_finished_flag_o && !receive_full_flag_o) begin
              data_rdata_o        <= shifter;
              receive_full_flag_o <= 1'b1;
              rx_hold             <= 1'b0;
              bit_idx             <= `I2CCE_IDX_ACK;
              state               <= ST_LO;
            end
          end else if (!nack_hold && direction_is_send_o && !transmit_empty_flag_o &&
                       !byte_finished_flag_o) begin
            // RULE14 - first data byte starts
            shifter               <= data_rdata_o;
            transmit_empty_flag_o <= 1'b1;
            bit_idx               <= `I2CCE_IDX_FIRST;
            state                 <= ST_LO;
          end else if (!nack_hold && !direction_is_send_o) begin
            bit_idx <= `I2CCE_IDX_FIRST;
            state   <= ST_LO;
          end else if (stop_pend) begin
            // RULE19 - stop clears both flags
            transmit_empty_flag_o <= 1'b0;
            byte_finished_flag_o  <= 1'b0;
            state                 <= ST_PLOW;
          end else if (start_pend) begin
            start_pend <= 1'b0;
            state      <= ST_RLOW;
          end
        end
        ST_LO: begin
          // RULE22 - msb first, ninth ack
          scl_oe_n_o <= `I2CCE_OE_DRIVE;
          sda_oe_n_o <= next_bit_rel;
          cnt        <= cnt + `I2CCE_CNT_STEP;
          if (phase_done) begin
            cnt        <= {CNT_W{1'b0}};
            scl_oe_n_o <= `I2CCE_OE_FLOAT;
            state      <= ST_HI;
          end
        end
        ST_HI: begin
          // RULE2 - pause while stretched
          if (next_cnt_hi_en) begin
            cnt <= cnt + `I2CCE_CNT_STEP;
          end
          if (phase_done) begin
            cnt        <= {CNT_W{1'b0}};
            scl_oe_n_o <= `I2CCE_OE_DRIVE;
            if (bit_idx != `I2CCE_IDX_ACK) begin
              if (!xfer_rx && shifter[`I2CCE_MSB] && !sda_s) begin
                // RULE24 - lost arbitration, let go
                controller_role_flag_o <= 1'b0;
                scl_oe_n_o             <= `I2CCE_OE_FLOAT;
                sda_oe_n_o             <= `I2CCE_OE_FLOAT;
                addr_phase             <= 1'b0;
                stop_pend              <= 1'b0;
                ten_done               <= 1'b0;
                state                  <= ST_IDLE;
              end else begin
                shifter <= {shifter[`I2CCE_MSB-1:0], sda_s};
                if (xfer_rx && bit_idx == `I2CCE_IDX_LAST) begin
                  if (receive_full_flag_o) begin
                    // RULE21 - unread byte, hold
                    byte_finished_flag_o <= 1'b1;
                    rx_hold              <= 1'b1;
                    state                <= ST_WAIT;
                  end else begin
                    // RULE20 - byte to holding, full
                    data_rdata_o        <= {shifter[`I2CCE_MSB-1:0], sda_s};
                    receive_full_flag_o <= 1'b1;
                    bit_idx             <= `I2CCE_IDX_ACK;
                    state               <= ST_LO;
                  end
                end else begin
                  bit_idx <= bit_idx + `I2CCE_IDX_STEP;
                  state   <= ST_LO;
                end
              end
            end else if (xfer_rx) begin
              // RULE5 - restart after byte
              bit_idx <= `I2CCE_IDX_FIRST;
              if (stop_pend) begin
                state <= ST_PLOW;
              end else if (start_pend) begin
                start_pend <= 1'b0;
                state      <= ST_RLOW;
              end else begin
                state <= ST_LO;
              end
            end else if (!ack_seen) begin
              // refused byte: hold and let software stop or restart
              nack_hold  <= 1'b1;
              addr_phase <= 1'b0;
              state      <= ST_WAIT;
            end else if (addr_phase) begin
              addr_phase <= 1'b0;
              state      <= ST_WAIT;
              if (hdr_phase) begin
                // RULE8 - header sent flag
                header_sent_flag_o <= 1'b1;
              end else begin
                // RULE9 - address done flag
                addr_done_flag_o <= 1'b1;
                if (direction_is_send_o) begin
                  transmit_empty_flag_o <= 1'b1;
                end
              end
            end else if (!transmit_empty_flag_o) begin
              // RULE15 - ack sets transmit empty
              shifter               <= data_rdata_o;
              transmit_empty_flag_o <= 1'b1;
              bit_idx               <= `I2CCE_IDX_FIRST;
              state                 <= ST_LO;
            end else if (stop_pend) begin
              // RULE19 - stop clears both flags
              transmit_empty_flag_o <= 1'b0;
              byte_finished_flag_o  <= 1'b0;
              state                 <= ST_PLOW;
            end else if (start_pend) begin
              // RULE5 - restart after byte
              start_pend <= 1'b0;
              state      <= ST_RLOW;
            end else begin
              // RULE16 - empty at end, hold
              byte_finished_flag_o <= 1'b1;
              state                <= ST_WAIT;
            end
          end
        end
        ST_RLOW: begin
          // release data while clock is low, then a fresh start
          scl_oe_n_o <= `I2CCE_OE_DRIVE;
          sda_oe_n_o <= `I2CCE_OE_FLOAT;
          cnt        <= cnt + `I2CCE_CNT_STEP;
          if (phase_done) begin
            cnt       <= {CNT_W{1'b0}};
            nack_hold <= 1'b0;
            state     <= ST_START;
          end
        end
        ST_PLOW: begin
          scl_oe_n_o <= `I2CCE_OE_DRIVE;
          sda_oe_n_o <= `I2CCE_OE_DRIVE;
          cnt        <= cnt + `I2CCE_CNT_STEP;
          if (phase_done) begin
            cnt        <= {CNT_W{1'b0}};
            scl_oe_n_o <= `I2CCE_OE_FLOAT;
            state      <= ST_PHI;
          end
        end
        ST_PHI: begin
          if (next_cnt_hi_en) begin
            cnt <= cnt + `I2CCE_CNT_STEP;
          end
          // RULE18 - stop ends controller role
          if (phase_done) begin
            cnt                    <= {CNT_W{1'b0}};
            sda_oe_n_o             <= `I2CCE_OE_FLOAT;
            controller_role_flag_o <= 1'b0;
            stop_pend              <= 1'b0;
            ten_done               <= 1'b0;
            nack_hold              <= 1'b0;
            state                  <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // i2cce_engine

`default_nettype wire

//--- tb/i2cce_target.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural bus target: acks whatever it is sent, answers reads with one fixed byte
module i2cce_target #(
  parameter logic [7:0] TX = 8'ha5
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       stretch_i,
  output var  logic       scl_oe_n_o,
  output var  logic       sda_oe_n_o,
  output var  logic [7:0] last_o
);
  logic [7:0] sh;
  logic [3:0] bitn;
  logic       first;
  logic       rd;
  logic       nack;
  // both lines released until the controller frames something
  initial begin
    scl_oe_n_o = 1'b1;
    sda_oe_n_o = 1'b1;
    bitn = 4'h0;
    first = 1'b0;
    rd = 1'b0;
    last_o = 8'h00;
  end
  // start or stop while the clock is high restarts framing
  always @(sda_i) if (scl_i) begin
    bitn = 4'h0;
    first = !sda_i;
    rd = 1'b0;
    sda_oe_n_o = 1'b1;
  end
  // bits taken msb first, ninth clock samples the ack
  always @(posedge scl_i) begin
    if (bitn < 4'h8) sh = {sh[6:0], sda_i};
    if (bitn == 4'h8) nack = sda_i;
    bitn = bitn + 4'h1;
  end
  // ack driven in the ninth clock, read data msb first
  always @(negedge scl_i) begin
    if (bitn == 4'h8) sda_oe_n_o = rd; // ack only bytes sent to us
    else if (bitn == 4'h9) begin
      last_o = sh;
      if (first) rd = sh[0];
      else if (rd && nack) rd = 1'b0; // a nack ends our sending
      first = 1'b0;
      bitn = 4'h0;
      sda_oe_n_o = !rd | TX[7];
    end else if (rd) sda_oe_n_o = TX[3'd7 - bitn[2:0]];
  end
  // holds the clock past the controller's own low phase
  always @(negedge scl_i) if (stretch_i) begin
    scl_oe_n_o = 1'b0;
    #150 scl_oe_n_o = 1'b1;
  end
endmodule // i2cce_target
`default_nettype wire

//--- tb/i2cce_engine_chk.sv
`timescale 1ns/10ps
`default_nettype none
// flag, interrupt and pin relations of the engine
module i2cce_chk #(
  parameter CNT_W = 12
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic start_req_i,
  input wire logic status_one_rd_i,
  input wire logic data_wr_i,
  input wire logic event_irq_enable_i,
  input wire logic buffer_irq_enable_i,
  input wire logic scl_oe_n_o,
  input wire logic sda_oe_n_o,
  input wire logic controller_role_flag_o,
  input wire logic start_done_flag_o,
  input wire logic addr_done_flag_o,
  input wire logic transmit_empty_flag_o,
  input wire logic byte_finished_flag_o,
  input wire logic bus_busy_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // start on idle bus takes the role
  start_role_a: assert property (start_req_i && !bus_busy_o && !controller_role_flag_o
    |-> ##[1:3] controller_role_flag_o) else $error("start did not take the role");
  // start flag only with both lines low
  start_lines_a: assert property ($rose(start_done_flag_o) |-> !sda_oe_n_o && !scl_oe_n_o)
    else $error("start flag without start on the lines");
  start_irq_a: assert property (start_done_flag_o && event_irq_enable_i |=> irq_o)
    else $error("start flag raised no interrupt");
  // status read then data write clears start
  start_clear_a: assert property (status_one_rd_i ##[1:2] data_wr_i |=> !start_done_flag_o)
    else $error("start flag not cleared");
  // clock held while an event waits
  hold_low_a: assert property ((start_done_flag_o || addr_done_flag_o || byte_finished_flag_o)
    [*2] |-> !scl_oe_n_o) else $error("clock released while an event waits");
  tx_irq_a: assert property (transmit_empty_flag_o && event_irq_enable_i && buffer_irq_enable_i
    |=> irq_o) else $error("transmit empty raised no interrupt");
  tx_stop_a: assert property ($fell(controller_role_flag_o) |-> !transmit_empty_flag_o
    && !byte_finished_flag_o) else $error("transmit flags survive the stop");
  // high phase waits out a stretched clock
  clock_stretch_a: assert property (scl_oe_n_o && !scl_i |=> scl_oe_n_o)
    else $error("clock pulled low during a stretch");
endmodule // i2cce_chk
bind i2cce_engine i2cce_chk #(.CNT_W(CNT_W)) i2cce_chk_inst (
  .sys_clk_i, .rst_n_i, .scl_i, .start_req_i, .status_one_rd_i, .data_wr_i,
  .event_irq_enable_i, .buffer_irq_enable_i, .scl_oe_n_o, .sda_oe_n_o,
  .controller_role_flag_o, .start_done_flag_o, .addr_done_flag_o,
  .transmit_empty_flag_o, .byte_finished_flag_o, .bus_busy_o, .irq_o);
`default_nettype wire

//--- tb/i2cce_engine_test.sv
`timescale 1ns/10ps
`default_nettype none
// compare: counts every check, reports and counts every mismatch
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module i2cce_engine_test;
  localparam int ST = 0, SP = 1, WR = 2, S1 = 3, S2 = 4, RD = 5;
  localparam int BF = 1, RF = 2, TE = 3, AD = 4, HS = 5, SD = 6, ROLE = 7;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        ack_en = 1'b1;
  logic        ten = 1'b0;
  logic        str = 1'b0;
  logic        ie = 1'b1;
  logic [5:0]  rq = 6'h00;
  logic [7:0]  wd = 8'h00;
  int          miscompares = 0;
  int          n_tests = 0;
  wire         scl_oe_n, sda_oe_n, t_scl_oe_n, t_sda_oe_n, irq, dir;
  wire [7:0]   fl, rdata, last;
  // released open-drain lines float up
  wire         scl = scl_oe_n & t_scl_oe_n;
  wire         sda = sda_oe_n & t_sda_oe_n;
  // rows: clock stretch, address byte, data sent or expected back
  logic [16:0] rows [3] = '{{1'b0, 8'h52, 8'h3c}, {1'b1, 8'ha1, 8'ha5}, {1'b0, 8'hfe, 8'h00}};
  i2cce_engine i2cce_engine_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .scl_o(),
    .scl_oe_n_o(scl_oe_n), .sda_o(), .sda_oe_n_o(sda_oe_n),
    // rise limit covers the two-flop input delay
    .clock_period_setting_i(12'h008), .rise_limit_setting_i(12'h004),
    .start_req_i(rq[ST]), .stop_req_i(rq[SP]), .ack_enable_i(ack_en), .ten_bit_mode_i(ten),
    .event_irq_enable_i(ie), .buffer_irq_enable_i(1'b1), .data_wr_i(rq[WR]),
    .data_wdata_i(wd), .data_rd_i(rq[RD]), .status_one_rd_i(rq[S1]), .status_two_rd_i(rq[S2]),
    .data_rdata_o(rdata), .controller_role_flag_o(fl[7]), .start_done_flag_o(fl[6]),
    .header_sent_flag_o(fl[5]), .addr_done_flag_o(fl[4]), .direction_is_send_o(dir),
    .transmit_empty_flag_o(fl[3]), .receive_full_flag_o(fl[2]), .byte_finished_flag_o(fl[1]),
    .bus_busy_o(fl[0]), .irq_o(irq));
  i2cce_target i2cce_target_inst (.scl_i(scl), .sda_i(sda), .stretch_i(str),
    .scl_oe_n_o(t_scl_oe_n), .sda_oe_n_o(t_sda_oe_n), .last_o(last));
  // module clock far above the fast-mode floor
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // one-cycle software access, launched on the falling edge
  task automatic acc(input int k, input logic [7:0] d = 8'h00);
    @(negedge sys_clk_i);
    rq[k] = 1'b1;
    wd = d;
    @(negedge sys_clk_i);
    rq = 6'h00;
  endtask
  // bounded wait on one flag
  task automatic wt(input int b, input logic v);
    int i;
    for (i = 0; i < 3000 && fl[b] !== v; i++) @(negedge sys_clk_i);
    `CHK("flag wait", v, fl[b])
  endtask
  task automatic rchk();
    `CHK("reset flags", 9'h000, {fl, irq})
    `CHK("reset lines", 2'b11, {scl_oe_n, sda_oe_n})
    `CHK("reset data", 8'h00, rdata)
  endtask
  // start plus seven-bit address, with one refused clear first
  task automatic open7(input logic [7:0] adr);
    acc(ST);
    wt(SD, 1'b1);
    `CHK("role", 1'b1, fl[ROLE])
    acc(WR, adr);
    `CHK("start kept", 1'b1, fl[SD])
    acc(S1);
    acc(WR, adr);
    `CHK("start done", 1'b0, fl[SD])
    wt(AD, 1'b1);
    `CHK("direction", ~adr[0], dir)
  endtask
  // clears the address event, writes one byte or reads two, and stops
  task automatic finish(input logic [7:0] adr, input logic [7:0] dat);
    acc(S1);
    acc(S2);
    `CHK("addr done", 1'b0, fl[AD])
    if (!adr[0]) begin
      acc(WR, dat);
      wt(BF, 1'b1);
      `CHK("tx empty", 1'b1, fl[TE])
      `CHK("irq", 1'b1, irq)
      acc(SP);
      wt(ROLE, 1'b0);
      `CHK("tx flags", 2'b00, {fl[TE], fl[BF]})
      `CHK("target byte", dat, last)
    end else begin
      wt(BF, 1'b1);
      ack_en = 1'b0; // second byte gets a nack
      acc(SP);
      acc(S1);
      acc(RD);
      `CHK("rx held", 1'b0, fl[BF])
      wt(RF, 1'b1);
      wt(ROLE, 1'b0);
      `CHK("rx byte", dat, rdata)
      acc(RD);
      ack_en = 1'b1;
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog, well past the run's length
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (3) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    rchk();
    for (int r = 0; r < 3; r++) begin
      str = rows[r][16];
      open7(rows[r][15:8]);
      finish(rows[r][15:8], rows[r][7:0]);
    end
    str = 1'b0;
    // ten-bit read: header, second byte, restart, read header
    ten = 1'b1;
    ie = 1'b0;
    acc(ST);
    wt(SD, 1'b1);
    `CHK("irq off", 1'b0, irq)
    ie = 1'b1;
    acc(S1);
    acc(WR, 8'hf0);
    wt(HS, 1'b1);
    acc(S1);
    acc(WR, 8'h5a);
    `CHK("header sent", 1'b0, fl[HS])
    wt(AD, 1'b1);
    acc(S1);
    acc(S2);
    acc(ST);
    wt(SD, 1'b1);
    `CHK("second byte", 8'h5a, last)
    acc(S1);
    acc(WR, 8'hf1);
    wt(AD, 1'b1);
    repeat (20) @(negedge sys_clk_i);
    `CHK("read header", 8'hf1, last)
    `CHK("direction", 1'b0, dir)
    finish(8'hf1, 8'ha5);
    ten = 1'b0;
    // reset after the start, with the clock held low, drops every flag and lets go of both lines
    acc(ST);
    wt(SD, 1'b1);
    rst_n_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    rchk();
    rst_n_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rchk();
    end_of_test();
  end
endmodule // i2cce_engine_test
`default_nettype wire
